// ### logic/self_prog_ctrl.sv
// self-programming sequencer, page buffer, fuse and lock store
// assumes core instruction strobes and flash handshake are synchronous to clk_i
//
// The register addresses and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
module self_prog_ctrl (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [31:0] s_awaddr_i,
  input wire logic s_awvalid_i,
  output logic s_awready_o,
  input wire logic [31:0] s_wdata_i,
  input wire logic [3:0] s_wstrb_i,
  input wire logic s_wvalid_i,
  output logic s_wready_o,
  output logic [1:0] s_bresp_o,
  output logic s_bvalid_o,
  input wire logic s_bready_i,
  input wire logic [31:0] s_araddr_i,
  input wire logic s_arvalid_i,
  output logic s_arready_o,
  output logic [31:0] s_rdata_o,
  output logic [1:0] s_rresp_o,
  output logic s_rvalid_o,
  input wire logic s_rready_i,
  input wire logic store_instr_i,
  input wire logic load_instr_i,
  input wire logic [15:0] ptr_i,
  input wire logic [15:0] data_i,
  output logic [7:0] load_data_o,
  output logic load_valid_o,
  output logic cpu_halt_o,
  output spm_pkg::flash_req_t flash_req_o,
  output logic flash_req_valid_o,
  input wire logic flash_done_i,
  input wire logic [spm_pkg::WORD_IDX_W-1:0] flash_idx_i,
  output logic [15:0] flash_word_o,
  input wire logic prog_mode_i,
  input wire logic nv_wr_i,
  input wire logic [1:0] nv_sel_i,
  input wire logic [7:0] nv_data_i,
  input wire logic chip_erase_i,
  input wire logic eeprom_busy_i,
  output spm_pkg::fuse_set_t fuse_o,
  output logic eeprom_preserve_o,
  output logic prog_block_o,
  output logic read_block_o
);
  import spm_pkg::*;

  seq_state_t state_r;
  logic [5:0] ctrl_r;
  logic [2:0] win_cnt_r;
  logic [31:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic aw_got_r;
  logic w_got_r;
  logic rd_ctrl_r;
  logic [7:0] nv_low_r;
  logic [7:0] nv_high_r;
  logic [7:0] nv_ext_r;
  logic [7:0] nv_lock_r;
  logic prog_mode_r;
  logic init_r;
  logic [15:0] buf_r [PAGE_WORDS];
  logic wr_fire;
  logic ctrl_wr;
  logic armed;
  logic store_ok;
  logic load_ok;
  logic buf_load;
  logic buf_clr;
  logic [7:0] load_sel;

  function automatic logic [1:0] lock_level(input logic [1:0] lb);
    unique case (lb)
      2'b11: lock_level = 2'h0;
      2'b10: lock_level = 2'h1;
      2'b00: lock_level = 2'h2;
      default: lock_level = 2'h3;
    endcase
  endfunction

  // ---------------- AXI4-Lite slave ----------------
  assign wr_fire = aw_got_r && w_got_r && !s_bvalid_o;
  assign ctrl_wr = wr_fire && aw_addr_r[3:0] == CTRL_OFS[3:0] && aw_addr_r[31:4] == 28'h0
    && w_strb_r[0] && !eeprom_busy_i && state_r != ST_BUSY;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      aw_got_r <= 1'b0;
      aw_addr_r <= 32'h0;
      s_awready_o <= 1'b1;
    end else if (s_awvalid_i && s_awready_o) begin
      aw_got_r <= 1'b1;
      aw_addr_r <= s_awaddr_i;
      s_awready_o <= 1'b0;
    end else if (wr_fire) begin
      aw_got_r <= 1'b0;
      s_awready_o <= 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      w_got_r <= 1'b0;
      w_data_r <= 32'h0;
      w_strb_r <= 4'h0;
      s_wready_o <= 1'b1;
    end else if (s_wvalid_i && s_wready_o) begin
      w_got_r <= 1'b1;
      w_data_r <= s_wdata_i;
      w_strb_r <= s_wstrb_i;
      s_wready_o <= 1'b0;
    end else if (wr_fire) begin
      w_got_r <= 1'b0;
      s_wready_o <= 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_bvalid_o <= 1'b0;
      s_bresp_o <= RESP_OKAY;
    end else if (wr_fire) begin
      s_bvalid_o <= 1'b1;
      s_bresp_o <= (aw_addr_r[31:4] == 28'h0 && aw_addr_r[1:0] == 2'h0) ? RESP_OKAY
        : RESP_SLVERR;
    end else if (s_bready_i) begin
      s_bvalid_o <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_arready_o <= 1'b1;
      s_rvalid_o <= 1'b0;
      s_rdata_o <= 32'h0;
      s_rresp_o <= RESP_OKAY;
      rd_ctrl_r <= 1'b0;
    end else if (s_arvalid_i && s_arready_o) begin
      s_arready_o <= 1'b0;
      s_rvalid_o <= 1'b1;
      s_rresp_o <= RESP_OKAY;
      rd_ctrl_r <= s_araddr_i == CTRL_OFS;
      if (s_araddr_i == CTRL_OFS) begin
        s_rdata_o <= {26'h0, ctrl_r};
      end else if (s_araddr_i == STATUS_OFS) begin
        s_rdata_o <= {24'h0, prog_block_o, read_block_o, eeprom_preserve_o,
          eeprom_busy_i, cpu_halt_o, state_r};
      end else if (s_araddr_i == FUSE_OFS) begin
        s_rdata_o <= {8'h0, fuse_o};
      end else if (s_araddr_i == LOCK_OFS) begin
        s_rdata_o <= {24'h0, nv_lock_r};
      end else begin
        s_rdata_o <= 32'h0;
        s_rresp_o <= RESP_SLVERR;
      end
    end else if (s_rvalid_o && s_rready_i) begin
      s_rvalid_o <= 1'b0;
      s_arready_o <= 1'b1;
    end
  end

  // ---------------- command sequencer ----------------
  assign armed = state_r == ST_ARMED && ctrl_r[EN_BIT];
  assign store_ok = armed && store_instr_i && !eeprom_busy_i
    && !fuse_o.ext[SELF_PROG_POS];
  assign load_ok = armed && load_instr_i && !eeprom_busy_i && !store_instr_i
    && win_cnt_r > STORE_WIN - LOAD_WIN && (ctrl_r[SIG_BIT] || ctrl_r[FLR_BIT]);
  assign buf_load = store_ok && ctrl_r[5:1] == 5'h00;

  always_comb begin
    load_sel = 8'h00;
    if (ctrl_r[SIG_BIT]) begin
      unique case (ptr_i[5:0])
        6'h00: load_sel = SIG_BYTE0;
        6'h02: load_sel = SIG_BYTE1;
        6'h04: load_sel = SIG_BYTE2;
        default: load_sel = 8'h00;
      endcase
    end else begin
      unique case (ptr_i[1:0])
        SEL_LOW: load_sel = nv_low_r;
        SEL_LOCK: load_sel = nv_lock_r;
        SEL_EXT: load_sel = nv_ext_r;
        SEL_HIGH: load_sel = nv_high_r;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_r <= ST_IDLE;
      ctrl_r <= CTRL_RST;
      win_cnt_r <= 3'h0;
      cpu_halt_o <= 1'b0;
      flash_req_valid_o <= 1'b0;
      flash_req_o <= '0;
    end else begin
      flash_req_valid_o <= 1'b0;
      unique case (state_r)
        ST_IDLE, ST_ARMED: begin
          if (ctrl_wr && w_data_r[EN_BIT]) begin
            ctrl_r <= w_data_r[5:0] & ~(6'h01 << CLR_BIT);
            win_cnt_r <= STORE_WIN;
            state_r <= ST_ARMED;
          end else if (store_ok && (ctrl_r[PGW_BIT] || ctrl_r[ERS_BIT])) begin
            flash_req_o.write <= ctrl_r[PGW_BIT];
            flash_req_o.erase <= !ctrl_r[PGW_BIT];
            flash_req_o.page <= ctrl_r[PGW_BIT] ? ptr_i[15:PAGE_LSB]
              : {ptr_i[15:PAGE_LSB+2], 2'h0};
            flash_req_valid_o <= 1'b1;
            cpu_halt_o <= 1'b1;
            state_r <= ST_BUSY;
          end else if (store_ok || load_ok || (armed && win_cnt_r == 3'h1)) begin
            ctrl_r <= CTRL_RST;
            win_cnt_r <= 3'h0;
            state_r <= ST_IDLE;
          end else if (state_r == ST_ARMED) begin
            win_cnt_r <= win_cnt_r - 3'h1;
          end
        end
        ST_BUSY: begin
          if (flash_done_i) begin
            ctrl_r <= CTRL_RST;
            cpu_halt_o <= 1'b0;
            state_r <= ST_IDLE;
          end
        end
        default: begin
          state_r <= ST_IDLE;
          ctrl_r <= CTRL_RST;
          cpu_halt_o <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      load_valid_o <= 1'b0;
      load_data_o <= 8'h00;
    end else begin
      load_valid_o <= load_ok;
      if (load_ok) begin
        load_data_o <= load_sel;
      end
    end
  end

  // ---------------- temporary page buffer ----------------
  assign buf_clr = (ctrl_wr && w_data_r[CLR_BIT])
    || (state_r == ST_BUSY && flash_done_i && flash_req_o.write)
    || eeprom_busy_i;

  for (genvar i = 0; i < PAGE_WORDS; i++) begin : g_buf
    always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        buf_r[i] <= 16'h0;
      end else if (buf_clr) begin
        buf_r[i] <= 16'h0;
      end else if (buf_load && ptr_i[WORD_IDX_W:1] == WORD_IDX_W'(i)) begin
        buf_r[i] <= data_i;
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      flash_word_o <= 16'h0;
    end else begin
      flash_word_o <= buf_r[flash_idx_i];
    end
  end

  // ---------------- fuse and lock store ----------------
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      nv_low_r <= LOW_FUSE_RST;
      nv_high_r <= HIGH_FUSE_RST;
      nv_ext_r <= EXT_FUSE_RST;
    end else if (prog_mode_i && nv_wr_i && nv_lock_r[0]) begin
      unique case (nv_sel_i)
        SEL_LOW: nv_low_r <= nv_data_i;
        SEL_HIGH: nv_high_r <= nv_data_i;
        SEL_EXT: nv_ext_r <= nv_data_i | 8'he0;
        SEL_LOCK: nv_low_r <= nv_low_r;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      nv_lock_r <= LOCK_RST;
    end else if (prog_mode_i && chip_erase_i) begin
      nv_lock_r <= LOCK_RST;
    end else if (prog_mode_i && nv_wr_i && nv_sel_i == SEL_LOCK) begin
      if (lock_level(nv_data_i[1:0]) != 2'h3
          && lock_level(nv_data_i[1:0]) > lock_level(nv_lock_r[1:0])) begin
        nv_lock_r <= {6'h3f, nv_data_i[1:0]};
      end else begin
        nv_lock_r <= LOCK_MAX;
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      init_r <= 1'b0;
      prog_mode_r <= 1'b0;
      fuse_o <= '{ext: EXT_FUSE_RST, high: HIGH_FUSE_RST, low: LOW_FUSE_RST};
      eeprom_preserve_o <= 1'b0;
      prog_block_o <= 1'b0;
      read_block_o <= 1'b0;
    end else begin
      init_r <= 1'b1;
      prog_mode_r <= prog_mode_i;
      if (!init_r || prog_mode_i != prog_mode_r) begin
        fuse_o <= '{ext: nv_ext_r, high: nv_high_r, low: nv_low_r};
      end
      eeprom_preserve_o <= !nv_high_r[EEPROM_PRESERVE_FUSE_POS];
      prog_block_o <= lock_level(nv_lock_r[1:0]) != 2'h0;
      read_block_o <= nv_lock_r[1:0] == 2'b00;
    end
  end

  // ---------------- assertions ----------------
  a_ctrl_high_zero: assert property (@(posedge clk_i) disable iff (!nrst_i)
    s_rvalid_o && rd_ctrl_r |-> s_rdata_o[7:6] == 2'h0)
    else $error("control bits 7:6 read nonzero");

  a_window_bound: assert property (@(posedge clk_i) disable iff (!nrst_i)
    state_r == ST_ARMED |-> win_cnt_r >= 3'h1 && win_cnt_r <= STORE_WIN)
    else $error("store window counter out of range");

  a_window_expire: assert property (@(posedge clk_i) disable iff (!nrst_i)
    state_r == ST_ARMED && win_cnt_r == 3'h1 && !ctrl_wr |=>
      state_r == ST_BUSY || (state_r == ST_IDLE && ctrl_r == CTRL_RST))
    else $error("command bits survived the window");

  a_store_needs_fuse: assert property (@(posedge clk_i) disable iff (!nrst_i)
    flash_req_valid_o |-> $past(!fuse_o.ext[SELF_PROG_POS]) && $past(!eeprom_busy_i))
    else $error("flash operation without self-program fuse");

  a_halt_busy: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (state_r == ST_BUSY) == cpu_halt_o && (state_r != ST_BUSY || ctrl_r[EN_BIT]))
    else $error("halt or enable not held during flash operation");

  a_busy_release: assert property (@(posedge clk_i) disable iff (!nrst_i)
    state_r == ST_BUSY && flash_done_i |=> ctrl_r == CTRL_RST && !cpu_halt_o)
    else $error("command bits not cleared after flash operation");

  a_lock_raise: assert property (@(posedge clk_i) disable iff (!nrst_i)
    $changed(nv_lock_r) && !$past(chip_erase_i) |->
      lock_level(nv_lock_r[1:0]) > lock_level($past(nv_lock_r[1:0])))
    else $error("lock protection lowered");

  a_fuse_frozen: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !nv_lock_r[0] |=> $stable({nv_low_r, nv_high_r, nv_ext_r}))
    else $error("fuse changed while locked");

  a_fuse_latched: assert property (@(posedge clk_i) disable iff (!nrst_i)
    init_r && prog_mode_i == prog_mode_r |=> $stable(fuse_o))
    else $error("effective fuses changed inside programming mode");

  a_load_answer: assert property (@(posedge clk_i) disable iff (!nrst_i)
    armed && load_instr_i && !store_instr_i && !eeprom_busy_i && ctrl_r[FLR_BIT]
      && win_cnt_r >= 3'h2 |=> load_valid_o ##1 !load_valid_o)
    else $error("fuse read not answered");

  a_no_cmd_plain: assert property (@(posedge clk_i) disable iff (!nrst_i)
    state_r == ST_IDLE && !(ctrl_wr && w_data_r[EN_BIT]) |=> state_r == ST_IDLE)
    else $error("command started without enable bit");
endmodule

// ### logic/spm_pkg.sv
// constants and carrier types for the self-programming controller
// assumes one 200 MHz clock and a 32-bit AXI4-Lite register bus
package spm_pkg;
  localparam logic [31:0] CTRL_OFS = 32'h0000_0000;
  localparam logic [31:0] STATUS_OFS = 32'h0000_0004;
  localparam logic [31:0] FUSE_OFS = 32'h0000_0008;
  localparam logic [31:0] LOCK_OFS = 32'h0000_000c;
  localparam int SIG_BIT = 5;
  localparam int CLR_BIT = 4;
  localparam int FLR_BIT = 3;
  localparam int PGW_BIT = 2;
  localparam int ERS_BIT = 1;
  localparam int EN_BIT = 0;
  localparam logic [2:0] STORE_WIN = 3'h4;
  localparam logic [2:0] LOAD_WIN = 3'h3;
  localparam logic [5:0] CTRL_RST = 6'h00;
  localparam logic [7:0] EXT_FUSE_RST = 8'hff;
  localparam logic [7:0] HIGH_FUSE_RST = 8'hdf;
  localparam logic [7:0] LOW_FUSE_RST = 8'h62;
  localparam logic [7:0] LOCK_RST = 8'hff;
  localparam logic [7:0] LOCK_MAX = 8'hfc;
  localparam int SELF_PROG_POS = 0;
  localparam int EEPROM_PRESERVE_FUSE_POS = 3;
  localparam int PAGE_WORDS = 16;
  localparam int WORD_IDX_W = 4;
  localparam int PAGE_LSB = 5;
  localparam int PAGE_W = 11;
  localparam logic [1:0] SEL_LOW = 2'h0;
  localparam logic [1:0] SEL_LOCK = 2'h1;
  localparam logic [1:0] SEL_EXT = 2'h2;
  localparam logic [1:0] SEL_HIGH = 2'h3;
  // identity bytes: arbitrary neutral values
  localparam logic [7:0] SIG_BYTE0 = 8'h5a;
  localparam logic [7:0] SIG_BYTE1 = 8'h01;
  localparam logic [7:0] SIG_BYTE2 = 8'h02;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [7:0] ext;
    logic [7:0] high;
    logic [7:0] low;
  } fuse_set_t;

  typedef struct packed {
    logic write;
    logic erase;
    logic [PAGE_W-1:0] page;
  } flash_req_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ARMED = 3'b010,
    ST_BUSY = 3'b100
  } seq_state_t;
endpackage

// ### sim/core_model.sv
// processor core model: issues program store and load strobes
// assumes the controller samples strobes, pointer and data on rising clk_i
`timescale 1ns/1ps
module core_model (
  input wire logic clk_i,
  input wire logic halt_i,
  input wire logic ld_valid_i,
  input wire logic [7:0] ld_data_i,
  output logic store_o,
  output logic load_o,
  output logic [15:0] ptr_o,
  output logic [15:0] data_o
);
  initial begin
    store_o = 1'b0;
    load_o = 1'b0;
    ptr_o = 16'h0000;
    data_o = 16'h0000;
  end

  // k idle cycles, one strobe, then the load result one cycle after it
  task automatic op(input logic st, input logic ld, input logic [15:0] p,
    input logic [15:0] d, input int k, output logic [7:0] q, output logic v);
    repeat (k) @(posedge clk_i);
    while (halt_i) @(posedge clk_i);
    store_o <= st;
    load_o <= ld;
    ptr_o <= p;
    data_o <= d;
    @(posedge clk_i);
    store_o <= 1'b0;
    load_o <= 1'b0;
    // released operands must not keep their last value
    ptr_o <= ~p;
    data_o <= ~d;
    @(posedge clk_i);
    v = ld_valid_i;
    q = ld_data_i;
  endtask
endmodule

// ### sim/tb.sv
// testbench for the self-programming controller
// assumes one 200 MHz clock and a register bus master kept by this bench
`timescale 1ns/1ps
module tb;
  import spm_pkg::*;
  typedef struct packed {
    logic [7:0] ctrl;
    logic [1:0] k;
    logic [15:0] p;
    logic v;
    logic [7:0] q;
  } row_t;
  logic clk_i, nrst_i, s_awvalid_i, s_wvalid_i, s_bready_i, s_arvalid_i, s_rready_i;
  logic [31:0] s_awaddr_i, s_wdata_i, s_araddr_i, s_rdata_o;
  logic [3:0] s_wstrb_i, flash_idx_i;
  logic s_awready_o, s_wready_o, s_bvalid_o, s_arready_o, s_rvalid_o;
  logic [1:0] s_bresp_o, s_rresp_o, nv_sel_i;
  logic store_instr_i, load_instr_i, load_valid_o, cpu_halt_o, flash_req_valid_o;
  logic [15:0] ptr_i, data_i, flash_word_o;
  logic [7:0] load_data_o, nv_data_i;
  flash_req_t flash_req_o;
  fuse_set_t fuse_o;
  logic flash_done_i, prog_mode_i, nv_wr_i, chip_erase_i, eeprom_busy_i;
  logic eeprom_preserve_o, prog_block_o, read_block_o, v;
  logic [1:0] r;
  logic [31:0] d;
  logic [7:0] q;
  int err_total = 0;
  int checks_done = 0;
  row_t rows [11] = '{
    '{8'h09, 2'd0, 16'h0000, 1'b1, 8'h62}, '{8'h09, 2'd0, 16'h0001, 1'b1, 8'hff},
    '{8'h09, 2'd0, 16'h0002, 1'b1, 8'hff}, '{8'h09, 2'd1, 16'h0003, 1'b1, 8'hdf},
    '{8'h09, 2'd2, 16'h0000, 1'b0, 8'h00}, '{8'h08, 2'd0, 16'h0000, 1'b0, 8'h00},
    '{8'h21, 2'd0, 16'h0000, 1'b1, SIG_BYTE0}, '{8'h21, 2'd0, 16'h0002, 1'b1, SIG_BYTE1},
    '{8'h21, 2'd1, 16'h0004, 1'b1, SIG_BYTE2}, '{8'h21, 2'd0, 16'h0001, 1'b1, 8'h00},
    '{8'h21, 2'd2, 16'h0000, 1'b0, 8'h00}};

  self_prog_ctrl DUT (
    .clk_i, .nrst_i, .s_awaddr_i, .s_awvalid_i, .s_awready_o, .s_wdata_i, .s_wstrb_i,
    .s_wvalid_i, .s_wready_o, .s_bresp_o, .s_bvalid_o, .s_bready_i, .s_araddr_i,
    .s_arvalid_i, .s_arready_o, .s_rdata_o, .s_rresp_o, .s_rvalid_o, .s_rready_i,
    .store_instr_i, .load_instr_i, .ptr_i, .data_i, .load_data_o, .load_valid_o,
    .cpu_halt_o, .flash_req_o, .flash_req_valid_o, .flash_done_i, .flash_idx_i,
    .flash_word_o, .prog_mode_i, .nv_wr_i, .nv_sel_i, .nv_data_i, .chip_erase_i,
    .eeprom_busy_i, .fuse_o, .eeprom_preserve_o, .prog_block_o, .read_block_o);

  core_model core (.clk_i, .halt_i(cpu_halt_o), .ld_valid_i(load_valid_o),
    .ld_data_i(load_data_o), .store_o(store_instr_i), .load_o(load_instr_i),
    .ptr_o(ptr_i), .data_o(data_i));

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  task automatic results;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string n);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", n, exp, seen);
    end
  endtask

  // bready and rready stay high, so every answer is taken when sampled
  task automatic axi_wr(input logic [31:0] a, input logic [31:0] dd);
    s_awaddr_i <= a;
    s_wdata_i <= dd;
    s_awvalid_i <= 1'b1;
    s_wvalid_i <= 1'b1;
    forever begin
      @(posedge clk_i);
      if (s_awready_o) s_awvalid_i <= 1'b0;
      if (s_wready_o) s_wvalid_i <= 1'b0;
      if (s_bvalid_o) begin
        r = s_bresp_o;
        break;
      end
    end
  endtask

  task automatic axi_rd(input logic [31:0] a);
    s_araddr_i <= a;
    s_arvalid_i <= 1'b1;
    forever begin
      @(posedge clk_i);
      if (s_arready_o) s_arvalid_i <= 1'b0;
      if (s_rvalid_o) begin
        d = s_rdata_o;
        r = s_rresp_o;
        break;
      end
    end
  endtask

  task automatic rchk(input logic [31:0] a, input logic [31:0] e, input string n);
    axi_rd(a);
    chk(d, e, n);
  endtask

  task automatic bufw(input logic [3:0] i, input logic [15:0] e);
    flash_idx_i <= i;
    repeat (2) @(posedge clk_i);
    chk(32'(flash_word_o), 32'(e), "flash_word_o");
  endtask

  task automatic nv(input logic [1:0] s, input logic [7:0] dd);
    nv_sel_i <= s;
    nv_data_i <= dd;
    nv_wr_i <= 1'b1;
    @(posedge clk_i);
    nv_wr_i <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask

  task automatic pulse_done;
    flash_done_i <= 1'b1;
    @(posedge clk_i);
    flash_done_i <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask

  initial begin
    repeat (20000) @(posedge clk_i);
    err_total++;
    results;
  end

  initial begin
    {nrst_i, s_awvalid_i, s_wvalid_i, s_arvalid_i, nv_wr_i, chip_erase_i} = '0;
    {flash_done_i, prog_mode_i, eeprom_busy_i, nv_sel_i, nv_data_i, flash_idx_i} = '0;
    {s_awaddr_i, s_wdata_i, s_araddr_i} = '0;
    s_wstrb_i = 4'hf;
    s_bready_i = 1'b1;
    s_rready_i = 1'b1;
    repeat (4) @(posedge clk_i);
    nrst_i <= 1'b1;
    chk(32'(fuse_o), 32'h00ffdf62, "fuse_o");
    rchk(FUSE_OFS, 32'h00ffdf62, "fuses");
    rchk(LOCK_OFS, 32'h000000ff, "lock");
    axi_wr(32'h0000_0010, 32'h0);
    chk(32'(r), 32'(RESP_SLVERR), "bresp");
    axi_rd(32'h0000_0010);
    chk(32'(r), 32'(RESP_SLVERR), "rresp");
    axi_wr(CTRL_OFS, 32'hc1);
    rchk(CTRL_OFS, 32'h01, "ctrl");
    foreach (rows[i]) begin
      axi_wr(CTRL_OFS, {24'h0, rows[i].ctrl});
      core.op(1'b0, 1'b1, rows[i].p, 16'h0, int'(rows[i].k), q, v);
      chk(32'(v), 32'(rows[i].v), "load_valid_o");
      if (rows[i].v) chk(32'(q), 32'(rows[i].q), "load_data_o");
      repeat (5) @(posedge clk_i);
    end
    axi_wr(CTRL_OFS, 32'h01);
    core.op(1'b1, 1'b0, 16'h0006, 16'hbeef, 0, q, v);
    bufw(4'h3, 16'h0000);
    prog_mode_i <= 1'b1;
    nv(SEL_HIGH, 8'hd7);
    chk(32'(eeprom_preserve_o), 32'h1, "eeprom_preserve_o");
    nv(SEL_EXT, 8'hfe);
    chk(32'(fuse_o), 32'h00ffdf62, "fuse_o");
    prog_mode_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk(32'(fuse_o), 32'h00fed762, "fuse_o");
    axi_wr(CTRL_OFS, 32'h01);
    core.op(1'b1, 1'b0, 16'h0007, 16'hbeef, 2, q, v);
    rchk(CTRL_OFS, 32'h0, "ctrl");
    bufw(4'h3, 16'hbeef);
    axi_wr(CTRL_OFS, 32'h01);
    core.op(1'b1, 1'b0, 16'h0008, 16'h1234, 3, q, v);
    rchk(CTRL_OFS, 32'h0, "ctrl");
    bufw(4'h4, 16'h0000);
    axi_wr(CTRL_OFS, 32'h10);
    bufw(4'h3, 16'h0000);
    axi_wr(CTRL_OFS, 32'h01);
    core.op(1'b1, 1'b0, 16'h0004, 16'h1234, 0, q, v);
    axi_wr(CTRL_OFS, 32'h05);
    core.op(1'b1, 1'b0, 16'h00e0, 16'hffff, 0, q, v);
    chk(32'(flash_req_valid_o), 32'h1, "flash_req_valid_o");
    chk(32'(flash_req_o), 32'h1007, "flash_req_o");
    chk(32'(cpu_halt_o), 32'h1, "cpu_halt_o");
    rchk(CTRL_OFS, 32'h05, "ctrl");
    pulse_done;
    chk(32'(cpu_halt_o), 32'h0, "cpu_halt_o");
    rchk(CTRL_OFS, 32'h0, "ctrl");
    bufw(4'h2, 16'h0000);
    axi_wr(CTRL_OFS, 32'h03);
    core.op(1'b1, 1'b0, 16'h00e0, 16'h5555, 0, q, v);
    chk(32'(flash_req_o), 32'h0804, "flash_req_o");
    chk(32'(cpu_halt_o), 32'h1, "cpu_halt_o");
    pulse_done;
    chk(32'(cpu_halt_o), 32'h0, "cpu_halt_o");
    rchk(CTRL_OFS, 32'h0, "ctrl");
    axi_wr(CTRL_OFS, 32'h05);
    repeat (6) @(posedge clk_i);
    rchk(CTRL_OFS, 32'h0, "ctrl");
    axi_wr(CTRL_OFS, 32'h03);
    repeat (6) @(posedge clk_i);
    rchk(CTRL_OFS, 32'h0, "ctrl");
    axi_wr(CTRL_OFS, 32'h09);
    eeprom_busy_i <= 1'b1;
    core.op(1'b0, 1'b1, 16'h0001, 16'h0000, 0, q, v);
    chk(32'(v), 32'h0, "load_valid_o");
    axi_wr(CTRL_OFS, 32'h09);
    rchk(CTRL_OFS, 32'h0, "ctrl");
    eeprom_busy_i <= 1'b0;
    s_wstrb_i <= 4'h0;
    axi_wr(CTRL_OFS, 32'h01);
    rchk(CTRL_OFS, 32'h0, "ctrl");
    s_wstrb_i <= 4'hf;
    prog_mode_i <= 1'b1;
    nv(SEL_LOCK, 8'hfe);
    chk(32'({prog_block_o, read_block_o}), 32'h2, "lock blocks");
    nv(SEL_LOW, 8'h00);
    rchk(FUSE_OFS, 32'h00fed762, "fuses");
    nv(SEL_LOCK, 8'hfe);
    rchk(LOCK_OFS, 32'h000000fc, "lock");
    chk(32'(read_block_o), 32'h1, "read_block_o");
    chip_erase_i <= 1'b1;
    @(posedge clk_i);
    chip_erase_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rchk(LOCK_OFS, 32'h000000ff, "lock");
    prog_mode_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk(32'(fuse_o), 32'h00fed762, "fuse_o");
    axi_wr(CTRL_OFS, 32'h01);
    core.op(1'b1, 1'b0, 16'h000a, 16'h5555, 0, q, v);
    bufw(4'h5, 16'h5555);
    nrst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    nrst_i <= 1'b1;
    bufw(4'h5, 16'h0000);
    chk(32'(fuse_o), 32'h00ffdf62, "fuse_o");
    results;
  end
endmodule
